//--- tmc_timer_ctrl.sv
`timescale 1ns/100ps
// Operation
// [R1] Interrupt source field: 0x all events, 10 input events only, 11 reload/compare only.
// [R2] Dead-band code 000 means no delay, otherwise two to the code cycles.
// [R3] Capture flag tells whether the latest interrupt came from an input capture.
// [R4] The timer counts only while the enable bit is set.
// [R5] Mode is the high mode bit above the three-bit mode field, eleven codes.
// [R6] Toggle modes: output equals polarity while disabled, toggles on reload when enabled.
// [R7] Counter mode counts on selected input edge; output toggles after each reload.
// [R8] Single PWM: idle at polarity, match drives active, reload drives inactive.
// [R9] Capture and capture restart modes capture on the selected input edge.
// [R10] Gated mode counts while input is active and interrupts on its deassertion.
// [R11] Capture/compare starts counting on the first edge, captures on later edges.
// [R12] Dual PWM: output and complement idle opposite, match and reload swap them.
// [R13] Dual PWM inserts the dead-band delay before either line goes active.
// [R14] The output pin follows polarity while disabled, whatever the port direction.
// [R15] Polarity changes while running do not move the output until its next event.
// [R16] Prescaler divides by two to the prescale field, one to 128.
// [R17] Prescaler clears whenever the timer is disabled.
// [R18] At the reload value the count restarts at one; compare uses the same value.
// [R19] In dual PWM the shared pin is the complement output, else timer input.
// [R20] Software writes zero to the reserved bit and uses only defined modes.
// [R21] Software changes mode, prescale and polarity only while the timer is disabled.
module tmc_timer_ctrl
(
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // Register port.
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // Reload and PWM values from the count registers.
   input  wire logic [15:0] reload_value_i [tmc_pkg::NUM_TIMERS],
   input  wire logic [15:0] pwm_value_i    [tmc_pkg::NUM_TIMERS],
   // Timer pins.
   input  wire logic        timer_input_i         [tmc_pkg::NUM_TIMERS],
   output logic             timer_output_pin_o    [tmc_pkg::NUM_TIMERS],
   output logic             timer_output_comp_o   [tmc_pkg::NUM_TIMERS],
   output logic             timer_output_comp_oe_o [tmc_pkg::NUM_TIMERS],
   // Timer state and events.
   output logic      [15:0] count_o   [tmc_pkg::NUM_TIMERS],
   output logic             capture_o [tmc_pkg::NUM_TIMERS],
   output logic             irq_o     [tmc_pkg::NUM_TIMERS]
);

   localparam int N = tmc_pkg::NUM_TIMERS;

   // ==========================================================================
   // State.
   logic [7:0]  ctl_a   [N];
   logic [7:0]  ctl_b   [N];
   logic        sync1   [N];
   logic        sync2   [N];
   logic        sync3   [N];
   logic [6:0]  pre     [N];
   logic [15:0] cnt     [N];
   logic        started [N];
   logic        tout    [N];
   logic        tcomp   [N];
   logic        comp_oe [N];
   logic        pend_out  [N];
   logic        pend_comp [N];
   logic [7:0]  db_cnt  [N];
   logic        cap_q   [N];
   logic        irq_q   [N];
   logic [7:0]  rdata;

   logic [7:0]  next_ctl_a   [N];
   logic [7:0]  next_ctl_b   [N];
   logic [6:0]  next_pre     [N];
   logic [15:0] next_cnt     [N];
   logic        next_started [N];
   logic        next_tout    [N];
   logic        next_tcomp   [N];
   logic        next_comp_oe [N];
   logic        next_pend_out  [N];
   logic        next_pend_comp [N];
   logic [7:0]  next_db_cnt  [N];
   logic        next_cap_q   [N];
   logic        next_irq_q   [N];
   logic [7:0]  next_rdata;

   // Decoded per-timer terms, also watched by the checks.
   tmc_pkg::tmc_mode_t mode [N];
   logic        en        [N];
   logic        pol       [N];
   logic        tick      [N];
   logic        sel_edge  [N];
   logic        lvl_act   [N];
   logic        advance   [N];
   logic        reload_ev [N];
   logic        match_ev  [N];
   logic        cap_ev    [N];

   // ==========================================================================
   // Next-state logic.
   always_comb
   begin
      logic       rise;
      logic       fall;
      logic       deassert;
      logic       in_ok;
      logic       gate_ev;
      logic       input_ev;
      logic       irq_ev;
      logic [1:0] irq_cfg;
      logic [2:0] db_code;
      logic [7:0] db_load;
      logic [6:0] pre_lim;
      rise     = 1'b0;
      fall     = 1'b0;
      deassert = 1'b0;
      in_ok    = 1'b0;
      gate_ev  = 1'b0;
      input_ev = 1'b0;
      irq_ev   = 1'b0;
      irq_cfg  = 2'h0;
      db_code  = 3'h0;
      db_load  = 8'h00;
      pre_lim  = 7'h00;
      next_rdata = 8'h00;
      for (int i = 0; i < N; i++)
      begin
         mode[i] = tmc_pkg::tmc_mode_t'({ctl_a[i][tmc_pkg::CA_MODE_MSB],
                   ctl_b[i][tmc_pkg::CB_MODE_HI:tmc_pkg::CB_MODE_LO]}); // see [R5]
         en[i]   = ctl_b[i][tmc_pkg::CB_EN];
         pol[i]  = ctl_b[i][tmc_pkg::CB_POL];
         irq_cfg = ctl_a[i][tmc_pkg::CA_IRQ_HI:tmc_pkg::CA_IRQ_LO];
         db_code = ctl_a[i][tmc_pkg::CA_DB_HI:tmc_pkg::CA_DB_LO];
         db_load = (tmc_pkg::DB_UNIT << db_code) - tmc_pkg::DB_UNIT; // see [R2]

         // Input pin is usable except where it carries the complement.
         in_ok       = (mode[i] != tmc_pkg::MODE_PWM_DUAL); // see [R19]
         rise        = in_ok && sync2[i] && !sync3[i];
         fall        = in_ok && !sync2[i] && sync3[i];
         sel_edge[i] = pol[i] ? fall : rise;
         deassert    = pol[i] ? rise : fall;
         lvl_act[i]  = in_ok && (sync2[i] != pol[i]);

         // Prescaler.
         pre_lim = (tmc_pkg::PRE_UNIT << ctl_b[i][tmc_pkg::CB_PRESCALE_SELECT_HI:tmc_pkg::CB_PRESCALE_SELECT_LO])
                   - tmc_pkg::PRE_UNIT; // see [R16]
         tick[i] = (pre[i] == pre_lim);
         if (!en[i] || tick[i])
            next_pre[i] = 7'h00; // see [R17]
         else
            next_pre[i] = pre[i] + 7'h01;

         // Count advance per mode.
         case (mode[i])
            tmc_pkg::MODE_COUNTER: advance[i] = en[i] && sel_edge[i]; // see [R7]
            tmc_pkg::MODE_GATED:   advance[i] = en[i] && tick[i] && lvl_act[i]; // see [R10]
            tmc_pkg::MODE_CAP_CMP: advance[i] = en[i] && tick[i] && started[i]; // see [R11]
            default:               advance[i] = en[i] && tick[i]; // see [R4]
         endcase

         reload_ev[i] = advance[i] && (cnt[i] == reload_value_i[i]); // see [R18]
         match_ev[i]  = advance[i] && (cnt[i] == pwm_value_i[i])
                        && (mode[i] == tmc_pkg::MODE_PWM_SINGLE || mode[i] == tmc_pkg::MODE_PWM_DUAL);
         cap_ev[i]    = en[i] && sel_edge[i]
                        && (mode[i] == tmc_pkg::MODE_CAPTURE || mode[i] == tmc_pkg::MODE_CAP_RESTART
                            || (mode[i] == tmc_pkg::MODE_CAP_CMP && started[i])); // see [R9]
         gate_ev      = en[i] && (mode[i] == tmc_pkg::MODE_GATED) && deassert; // see [R10]
         input_ev     = cap_ev[i] || gate_ev;

         // First selected edge starts the capture/compare count without interrupt.
         if (!en[i])
            next_started[i] = 1'b0;
         else if (mode[i] == tmc_pkg::MODE_CAP_CMP && sel_edge[i])
            next_started[i] = 1'b1; // see [R11]
         else
            next_started[i] = started[i];

         if (reload_ev[i] || (cap_ev[i] && mode[i] == tmc_pkg::MODE_CAP_RESTART))
            next_cnt[i] = tmc_pkg::CNT_RESTART; // see [R18]
         else if (advance[i])
            next_cnt[i] = cnt[i] + 16'h0001;
         else
            next_cnt[i] = cnt[i];

         // Interrupt source selection.
         if (!irq_cfg[1])
            irq_ev = reload_ev[i] || input_ev; // see [R1]
         else if (irq_cfg == tmc_pkg::IRQ_INPUT_ONLY)
            irq_ev = input_ev; // see [R1]
         else
            irq_ev = reload_ev[i]; // see [R1]
         next_irq_q[i] = irq_ev;
         next_cap_q[i] = cap_ev[i];

         // Register writes; the hardware capture flag update wins over software.
         next_ctl_a[i] = ctl_a[i];
         next_ctl_b[i] = ctl_b[i];
         if (reg_wr_i && reg_addr_i == tmc_pkg::ADDR_CTL_A[i])
            next_ctl_a[i] = reg_wdata_i;
         if (reg_wr_i && reg_addr_i == tmc_pkg::ADDR_CTL_B[i])
            next_ctl_b[i] = reg_wdata_i;
         else if (reload_ev[i] && mode[i] == tmc_pkg::MODE_ONE_SHOT)
            next_ctl_b[i][tmc_pkg::CB_EN] = 1'b0;
         if (irq_ev)
            next_ctl_a[i][tmc_pkg::CA_CAPFLAG] = cap_ev[i]; // see [R3]

         if (reg_rd_i && reg_addr_i == tmc_pkg::ADDR_CTL_A[i])
            next_rdata = ctl_a[i];
         if (reg_rd_i && reg_addr_i == tmc_pkg::ADDR_CTL_B[i])
            next_rdata = ctl_b[i];

         // Output pins.
         next_comp_oe[i]   = !in_ok; // see [R19]
         next_tout[i]      = tout[i];
         next_tcomp[i]     = tcomp[i];
         next_pend_out[i]  = pend_out[i];
         next_pend_comp[i] = pend_comp[i];
         next_db_cnt[i]    = db_cnt[i];
         if (!en[i])
         begin
            next_tout[i]      = pol[i]; // see [R14] [R6] [R8] [R12]
            next_tcomp[i]     = !pol[i]; // see [R12]
            next_pend_out[i]  = 1'b0;
            next_pend_comp[i] = 1'b0;
            next_db_cnt[i]    = 8'h00;
         end
         else
         begin
            case (mode[i])
               tmc_pkg::MODE_PWM_SINGLE:
               begin
                  if (reload_ev[i])
                     next_tout[i] = pol[i]; // see [R8] [R15]
                  else if (match_ev[i])
                     next_tout[i] = !pol[i]; // see [R8]
               end
               tmc_pkg::MODE_PWM_DUAL:
               begin
                  if (pend_out[i] || pend_comp[i])
                  begin
                     if (db_cnt[i] == 8'h00)
                     begin
                        if (pend_out[i])
                           next_tout[i] = !pol[i]; // see [R13]
                        if (pend_comp[i])
                           next_tcomp[i] = !pol[i]; // see [R13]
                        next_pend_out[i]  = 1'b0;
                        next_pend_comp[i] = 1'b0;
                     end
                     else
                        next_db_cnt[i] = db_cnt[i] - 8'h01;
                  end
                  if (reload_ev[i])
                  begin
                     next_tout[i]     = pol[i]; // see [R12]
                     next_pend_out[i] = 1'b0;
                     if (db_code == tmc_pkg::DB_NONE)
                        next_tcomp[i] = !pol[i];
                     else
                     begin
                        next_pend_comp[i] = 1'b1; // see [R13]
                        next_db_cnt[i]    = db_load;
                     end
                  end
                  else if (match_ev[i])
                  begin
                     next_tcomp[i]     = pol[i]; // see [R12]
                     next_pend_comp[i] = 1'b0;
                     if (db_code == tmc_pkg::DB_NONE)
                        next_tout[i] = !pol[i];
                     else
                     begin
                        next_pend_out[i] = 1'b1; // see [R13]
                        next_db_cnt[i]   = db_load;
                     end
                  end
               end
               default:
               begin
                  if (reload_ev[i])
                     next_tout[i] = !tout[i]; // see [R6] [R7] [R15]
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Registers.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata <= 8'h00;
         for (int i = 0; i < N; i++)
         begin
            ctl_a[i]     <= tmc_pkg::CTL_A_RESET;
            ctl_b[i]     <= tmc_pkg::CTL_B_RESET;
            sync1[i]     <= 1'b0;
            sync2[i]     <= 1'b0;
            sync3[i]     <= 1'b0;
            pre[i]       <= 7'h00;
            cnt[i]       <= tmc_pkg::CNT_RESTART;
            started[i]   <= 1'b0;
            tout[i]      <= 1'b0;
            tcomp[i]     <= 1'b1;
            comp_oe[i]   <= 1'b0;
            pend_out[i]  <= 1'b0;
            pend_comp[i] <= 1'b0;
            db_cnt[i]    <= 8'h00;
            cap_q[i]     <= 1'b0;
            irq_q[i]     <= 1'b0;
         end
      end
      else
      begin
         rdata <= next_rdata;
         for (int i = 0; i < N; i++)
         begin
            ctl_a[i]     <= next_ctl_a[i];
            ctl_b[i]     <= next_ctl_b[i];
            sync1[i]     <= timer_input_i[i];
            sync2[i]     <= sync1[i];
            sync3[i]     <= sync2[i];
            pre[i]       <= next_pre[i];
            cnt[i]       <= next_cnt[i];
            started[i]   <= next_started[i];
            tout[i]      <= next_tout[i];
            tcomp[i]     <= next_tcomp[i];
            comp_oe[i]   <= next_comp_oe[i];
            pend_out[i]  <= next_pend_out[i];
            pend_comp[i] <= next_pend_comp[i];
            db_cnt[i]    <= next_db_cnt[i];
            cap_q[i]     <= next_cap_q[i];
            irq_q[i]     <= next_irq_q[i];
         end
      end
   end

   assign reg_rdata_o            = rdata;
   assign timer_output_pin_o     = tout;
   assign timer_output_comp_o    = tcomp;
   assign timer_output_comp_oe_o = comp_oe;
   assign count_o                = cnt;
   assign capture_o              = cap_q;
   assign irq_o                  = irq_q;

   // ==========================================================================
   // Checks on timer 0.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_idle;
      !en[0];
   endsequence

   sequence seq_dual_match2;
      en[0] && mode[0] == tmc_pkg::MODE_PWM_DUAL && match_ev[0] && !reload_ev[0]
      && ctl_a[0][tmc_pkg::CA_DB_HI:tmc_pkg::CA_DB_LO] == 3'h1;
   endsequence

   sequence seq_quiet;
      en[0] && !reload_ev[0] && !match_ev[0];
   endsequence
   AST_IRQ_RELOAD_ONLY: assert property (irq_q[0] && $past(ctl_a[0][6:5]) == 2'h3 |-> $past(reload_ev[0])) // see [R1]
      else $error("Reload-only interrupt without reload.");
   AST_IRQ_INPUT_ONLY: assert property (irq_q[0] && $past(ctl_a[0][6:5]) == 2'h2 |-> !$past(reload_ev[0])
      || $past(cap_ev[0]) || $past(mode[0]) == tmc_pkg::MODE_GATED) // see [R1]
      else $error("Input-only interrupt raised by reload.");
   AST_CAP_FLAG: assert property (cap_ev[0] && ctl_a[0][6:5] != 2'h3 |=> ctl_a[0][0] && capture_o[0]) // see [R3]
      else $error("Capture flag not set after capture interrupt.");
   AST_DISABLED_STILL: assert property (seq_idle |=> $stable(cnt[0]) && pre[0] == 7'h00) // see [R4]
      else $error("Timer moved while disabled.");
   AST_RELOAD_ONE: assert property (reload_ev[0] |=> cnt[0] == 16'h0001) // see [R18]
      else $error("Count did not restart at one.");
   AST_PRESCALE: assert property (en[0] && mode[0] == tmc_pkg::MODE_CONTINUOUS && !tick[0]
      |=> $stable(cnt[0])) // see [R16]
      else $error("Count advanced between prescaler ticks.");
   AST_IDLE_LEVEL: assert property (seq_idle |=> tout[0] == $past(pol[0])) // see [R6]
      else $error("Idle output differs from polarity.");
   AST_POL_HOLD: assert property (seq_quiet ##0 !pend_out[0] && !pend_comp[0] |=> $stable(tout[0])) // see [R15]
      else $error("Output moved without an output event.");
   AST_COUNTER_EDGE: assert property (en[0] && mode[0] == tmc_pkg::MODE_COUNTER && !sel_edge[0]
      |=> $stable(cnt[0])) // see [R7]
      else $error("Counter advanced without a selected edge.");
   AST_PWM_SINGLE: assert property (en[0] && mode[0] == tmc_pkg::MODE_PWM_SINGLE && match_ev[0] && !reload_ev[0]
      |=> tout[0] == !$past(pol[0])) // see [R8]
      else $error("Single PWM match level wrong.");
   AST_CAPTURE: assert property (en[0] && mode[0] == tmc_pkg::MODE_CAPTURE && sel_edge[0] |=> capture_o[0]) // see [R9]
      else $error("Selected edge not captured.");
   AST_GATED: assert property (en[0] && mode[0] == tmc_pkg::MODE_GATED && !lvl_act[0] |=> $stable(cnt[0])) // see [R10]
      else $error("Gated timer counted while input inactive.");
   AST_CAPCMP_START: assert property (en[0] && mode[0] == tmc_pkg::MODE_CAP_CMP && !started[0] && sel_edge[0]
      |=> started[0] && !capture_o[0]) // see [R11]
      else $error("Capture/compare start edge mishandled.");
   AST_DEADBAND: assert property (seq_dual_match2 ##1 seq_quiet [*2]
      |=> $changed(tout[0]) && tout[0] == !$past(pol[0], 3)) // see [R13] [R2]
      else $error("Dead-band delay wrong.");
   AST_DEADBAND_GAP: assert property (seq_dual_match2 |=> tcomp[0] == $past(pol[0]) && tout[0] == $past(tout[0])) // see [R12]
      else $error("Complement not released before output activation.");
   AST_COMP_PIN: assert property (##1 comp_oe[0] == ($past(mode[0]) == tmc_pkg::MODE_PWM_DUAL)) // see [R19]
      else $error("Complement drive enable wrong.");

endmodule

//--- tmc_pkg.sv
package tmc_pkg;

   // ==========================================================================
   // Instances and register map.
   localparam int          NUM_TIMERS = 2;
   localparam logic [11:0] ADDR_CTL_A [NUM_TIMERS] = '{12'hf06, 12'hf0e};
   localparam logic [11:0] ADDR_CTL_B [NUM_TIMERS] = '{12'hf07, 12'hf0f};

   // ==========================================================================
   // Field positions of control register A.
   localparam int CA_MODE_MSB = 7;
   localparam int CA_IRQ_HI   = 6;
   localparam int CA_IRQ_LO   = 5;
   localparam int CA_DB_HI    = 3;
   localparam int CA_DB_LO    = 1;
   localparam int CA_CAPFLAG  = 0;

   // ==========================================================================
   // Field positions of control register B.
   localparam int CB_EN      = 7;
   localparam int CB_POL     = 6;
   localparam int CB_PRESCALE_SELECT_HI = 5;
   localparam int CB_PRESCALE_SELECT_LO = 3;
   localparam int CB_MODE_HI = 2;
   localparam int CB_MODE_LO = 0;

   // ==========================================================================
   // Reset values and counting constants.
   localparam logic [7:0]  CTL_A_RESET   = 8'h00;
   localparam logic [7:0]  CTL_B_RESET   = 8'h00;
   localparam logic [15:0] CNT_RESTART   = 16'h0001;
   localparam logic [6:0]  PRE_UNIT      = 7'h01;
   localparam logic [7:0]  DB_UNIT       = 8'h01;
   localparam logic [2:0]  DB_NONE       = 3'h0;
   localparam logic [1:0]  IRQ_INPUT_ONLY  = 2'h2;
   localparam logic [1:0]  IRQ_RELOAD_ONLY = 2'h3;

   // ==========================================================================
   // Operating modes.
   typedef enum logic [3:0] {
      MODE_ONE_SHOT   = 4'h0,
      MODE_CONTINUOUS = 4'h1,
      MODE_COUNTER    = 4'h2,
      MODE_PWM_SINGLE = 4'h3,
      MODE_CAPTURE    = 4'h4,
      MODE_COMPARE    = 4'h5,
      MODE_GATED      = 4'h6,
      MODE_CAP_CMP    = 4'h7,
      MODE_PWM_DUAL   = 4'h8,
      MODE_CAP_RESTART = 4'h9,
      MODE_CMP_COUNTER = 4'ha
   } tmc_mode_t;

endpackage

//--- tmc_pin_partner.sv
`timescale 1ns/100ps
// ==========================================================================
// Outside logic on the timer input pins, answering promptly or slowly.
module tmc_pin_partner
(
   // Clock and pace.
   input  wire logic       core_clk_i,
   input  wire logic       slow_i,
   // Requested pin levels.
   input  wire logic [1:0] level_i,
   // Timer input pins.
   output logic            pin_o [tmc_pkg::NUM_TIMERS]
);
   logic [1:0] lag_q [3] = '{2'h0, 2'h0, 2'h0};

   always @(posedge core_clk_i)
   begin
      lag_q[0] <= level_i;
      lag_q[1] <= lag_q[0];
      lag_q[2] <= lag_q[1];
   end

   // A slow partner moves its pins two cycles later.
   assign pin_o[0] = slow_i ? lag_q[2][0] : lag_q[0][0];
   assign pin_o[1] = slow_i ? lag_q[2][1] : lag_q[0][1];
endmodule

//--- tb_timer_mode_control.sv
`timescale 1ns/100ps
// ==========================================================================
// Testbench of the timer mode and control block.
module tb_timer_mode_control;
   logic        core_clk_i = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic [11:0] addr       = 12'h000;
   logic [7:0]  wdata      = 8'h00;
   logic        wr         = 1'b0;
   logic        rd_s       = 1'b0;
   logic [7:0]  rdata;
   logic [15:0] reload     [tmc_pkg::NUM_TIMERS] = '{16'h0003, 16'h0003};
   logic [15:0] pwm        [tmc_pkg::NUM_TIMERS] = '{16'h000a, 16'h000a};
   logic        pin        [tmc_pkg::NUM_TIMERS];
   logic        out_pin    [tmc_pkg::NUM_TIMERS];
   logic        comp       [tmc_pkg::NUM_TIMERS];
   logic        comp_oe    [tmc_pkg::NUM_TIMERS];
   logic [15:0] count      [tmc_pkg::NUM_TIMERS];
   logic        capture    [tmc_pkg::NUM_TIMERS];
   logic        irq        [tmc_pkg::NUM_TIMERS];
   logic [1:0]  level      = 2'h0;
   logic        slow       = 1'b0;
   logic        dual_chk   = 1'b0;
   int          miscompares = 0;
   int          checks      = 0;
   int          c;
   int          c2;
   logic        o1;
   logic [15:0] cnt;

   always #10 core_clk_i = ~core_clk_i;

   tmc_timer_ctrl dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .reload_value_i(reload), .pwm_value_i(pwm),
      .timer_input_i(pin), .timer_output_pin_o(out_pin), .timer_output_comp_o(comp),
      .timer_output_comp_oe_o(comp_oe), .count_o(count), .capture_o(capture), .irq_o(irq));

   tmc_pin_partner partner (.core_clk_i(core_clk_i), .slow_i(slow), .level_i(level), .pin_o(pin));

   task automatic final_report;
      if (miscompares == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk_i);
      wr    <= 1'b0;
   endtask

   task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk_i);
      rd_s <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp}, "register read");
   endtask

   // Waits for an interrupt (sel 0) or capture pulse (sel 1) of timer 0.
   task automatic wait_ev(input bit sel, input int n, input bit must, output int cyc);
      logic seen;
      seen = 1'b0;
      cyc  = 0;
      while (seen !== 1'b1 && cyc < n)
      begin
         @(posedge core_clk_i);
         #1;
         cyc++;
         seen = sel ? capture[0] : irq[0];
      end
      checks++;
      if ((seen === 1'b1) != must)
      begin
         miscompares++;
         $display("MISMATCH %0t event presence wrong", $time);
         if (must)
            final_report();
      end
   endtask

   // Output and complement must never be active together in dual PWM.
   always @(negedge core_clk_i)
   begin
      if (dual_chk && (out_pin[0] !== 1'b0 && comp[0] !== 1'b0))
      begin
         miscompares++;
         $display("MISMATCH %0t output and complement both active", $time);
      end
   end

   initial
   begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < tmc_pkg::NUM_TIMERS; i++)
      begin
         rreg(tmc_pkg::ADDR_CTL_A[i], tmc_pkg::CTL_A_RESET);
         rreg(tmc_pkg::ADDR_CTL_B[i], tmc_pkg::CTL_B_RESET);
      end
      rreg(12'hf00, 8'h00);
      wreg(tmc_pkg::ADDR_CTL_A[1], 8'h4e);
      wreg(tmc_pkg::ADDR_CTL_B[1], 8'h3d);
      rreg(tmc_pkg::ADDR_CTL_A[1], 8'h4e);
      rreg(tmc_pkg::ADDR_CTL_B[1], 8'h3d);
      wreg(tmc_pkg::ADDR_CTL_B[1], 8'h00);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h41);
      @(posedge core_clk_i);
      #1 chk({15'h0, out_pin[0]}, 16'h1, "idle level pol 1");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h01);
      @(posedge core_clk_i);
      #1 chk({15'h0, out_pin[0]}, 16'h0, "idle level pol 0");
      for (int p = 0; p < 4; p++)
      begin
         wreg(tmc_pkg::ADDR_CTL_B[0], 8'h01 | 8'(p << 3));
         wreg(tmc_pkg::ADDR_CTL_B[0], 8'h81 | 8'(p << 3));
         wait_ev(0, 500, 1, c);
         o1 = out_pin[0];
         wait_ev(0, 500, 1, c);
         chk(16'(c), 16'(3 << p), "reload period");
         chk({15'h0, out_pin[0]}, {15'h0, ~o1}, "toggle on reload");
         wreg(tmc_pkg::ADDR_CTL_B[0], 8'h01);
      end
      repeat (3) @(posedge core_clk_i);
      cnt = count[0];
      repeat (10) @(posedge core_clk_i);
      chk(count[0], cnt, "count while disabled");
      wreg(tmc_pkg::ADDR_CTL_A[0], 8'h60);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h81);
      wait_ev(0, 20, 1, c);
      wreg(tmc_pkg::ADDR_CTL_A[0], 8'h40);
      repeat (2) @(posedge core_clk_i);
      wait_ev(0, 30, 0, c);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h01);
      wreg(tmc_pkg::ADDR_CTL_A[0], 8'h00);
      reload[0] <= 16'h0014;
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h43);
      @(posedge core_clk_i);
      #1 chk({15'h0, out_pin[0]}, 16'h1, "pwm idle pol 1");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h03);
      @(posedge core_clk_i);
      #1 chk({15'h0, out_pin[0]}, 16'h0, "pwm idle pol 0");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h83);
      wait_ev(0, 100, 1, c);
      repeat (2) @(posedge core_clk_i);
      chk({15'h0, out_pin[0]}, 16'h0, "pwm low after reload");
      repeat (12) @(posedge core_clk_i);
      chk({15'h0, out_pin[0]}, 16'h1, "pwm high after match");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h03);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h00);
      wreg(tmc_pkg::ADDR_CTL_A[0], 8'h84);
      @(posedge core_clk_i);
      #1 chk({14'h0, out_pin[0], comp[0]}, 16'h1, "dual idle pol 0");
      chk({15'h0, comp_oe[0]}, 16'h1, "complement drives pin");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h40);
      @(posedge core_clk_i);
      #1 chk({14'h0, out_pin[0], comp[0]}, 16'h2, "dual idle pol 1");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h00);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h80);
      dual_chk = 1'b1;
      wait_ev(0, 100, 1, c);
      wait_ev(0, 100, 1, c);
      repeat (4) @(posedge core_clk_i);
      chk({14'h0, out_pin[0], comp[0]}, 16'h0, "dead band holds complement");
      repeat (4) @(posedge core_clk_i);
      chk({14'h0, out_pin[0], comp[0]}, 16'h1, "complement active after delay");
      dual_chk = 1'b0;
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h00);
      wreg(tmc_pkg::ADDR_CTL_A[0], 8'h00);
      reload[0] <= 16'hffff;
      slow <= 1'b1;
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'hc4);
      level <= 2'h1;
      wait_ev(1, 10, 0, c);
      level <= 2'h0;
      wait_ev(1, 10, 1, c2);
      rreg(tmc_pkg::ADDR_CTL_A[0], 8'h01);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h04);
      slow <= 1'b0;
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h82);
      repeat (4) @(posedge core_clk_i);
      cnt = count[0];
      level <= 2'h3;
      repeat (8) @(posedge core_clk_i);
      chk(count[0], cnt + 16'h1, "count on rising input");
      level <= 2'h0;
      repeat (8) @(posedge core_clk_i);
      chk(count[0], cnt + 16'h1, "no count on falling input");
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h02);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h06);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h86);
      cnt = count[0];
      level <= 2'h1;
      repeat (8) @(posedge core_clk_i);
      level <= 2'h0;
      wait_ev(0, 10, 1, c);
      chk(count[0], cnt + 16'h8, "gated count");
      rreg(tmc_pkg::ADDR_CTL_A[0], 8'h00);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h06);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h07);
      wreg(tmc_pkg::ADDR_CTL_B[0], 8'h87);
      level <= 2'h1;
      wait_ev(1, 8, 0, c);
      level <= 2'h0;
      repeat (4) @(posedge core_clk_i);
      level <= 2'h1;
      wait_ev(1, 8, 1, c);
      final_report();
   end
endmodule
